// ---- logic/wdw_params.svh ----
/*
 Constants for the windowed watchdog: register offsets, field positions,
 reset values and timing counts. Assumes a 25 MHz system clock.
*/
`ifndef WDW_PARAMS_SVH
`define WDW_PARAMS_SVH

`define WDW_ADDR_CONTROL 4'h0
`define WDW_ADDR_CONFIG 4'h1
`define WDW_ADDR_OSCCTL 4'h2
`define WDW_ADDR_STATUS 4'h3
`define WDW_ADDR_IDENT 4'h4
`define WDW_ADDR_TUNE 4'h5

`define WDW_CTL_FLAG_BIT 7
`define WDW_CTL_SOFT_BIT 0
`define WDW_CFG_WIN_BIT 5
`define WDW_CFG_PS_HI 4
`define WDW_CFG_PS_LO 1
`define WDW_CFG_HARD_BIT 0
`define WDW_OSC_FS_HI 6
`define WDW_OSC_FS_LO 4
`define WDW_ST_TIMEOUT_BIT 0
`define WDW_ST_EARLY_BIT 1

`define WDW_CFG_RESET 8'h3F
`define WDW_CTL_RESET 8'h00
`define WDW_OSC_RESET 8'h00
`define WDW_QUADRANT4 8'hC0
`define WDW_IDENT_VALUE 8'h5A

`define WDW_CLK_HZ 25000000
`define WDW_BASE_US 4000
`define WDW_TICK_HZ 64000
`define WDW_TICK_DIV (`WDW_CLK_HZ / `WDW_TICK_HZ)
`define WDW_TUNE_RESET 8'h00

`endif

// ---- logic/wdw_pkg.sv ----
/*
 Types shared by the watchdog files. Assumes wdw_params.svh beside it.
*/
package wdw_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdw_bus_req_t;

   typedef enum logic [1:0] {
      WDW_OFF,
      WDW_RUN,
      WDW_FIRE
   } wdw_state_t;
endpackage

// ---- logic/wdw_tick_gen.sv ----
/*
 Internal RC clock model: divides the system clock to an oscillator tick
 whose period is stretched or shrunk by a signed tuning value.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "wdw_params.svh"

module wdw_tick_gen (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Control
   input wire logic run,
   input wire logic [7:0] tune,
   // Output
   output logic tick
);
   import wdw_pkg::*;

   localparam int unsigned BASE = `WDW_TICK_DIV;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [15:0] limit;

   // A tuning step lengthens the oscillator period by one part in 128.
   always_comb begin
      limit = 16'(BASE) + 16'(($signed(tune) * $signed(17'(BASE))) >>> 7);
      cnt_nxt = cnt_r;
      if (!run || cnt_r >= limit - 16'h0001) begin
         cnt_nxt = 16'h0000;
      end else begin
         cnt_nxt = cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tick = run && (cnt_r >= limit - 16'h0001);
endmodule

// ---- logic/wdw_watchdog.sv ----
/*
 Windowed watchdog timer with 8-bit base counter and 16-bit postscaler.
 Assumes a 25 MHz mclk, synchronous reset, and a plain register port
 driven by a master on the same clock. Event inputs are one-cycle pulses
 from logic on the same clock.
*/
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "wdw_params.svh"

module wdw_watchdog (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire wdw_pkg::wdw_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // Core events
   input wire logic sleep_instr,
   input wire logic clear_watchdog_instr,
   input wire logic clock_fail,
   input wire logic fscm_enable,
   // Results
   output logic internal_rc_clock_on,
   output logic wdt_reset_req,
   output logic window_flag
);
   import wdw_pkg::*;

   localparam int unsigned BASE_TICKS =
      `WDW_BASE_US * (`WDW_TICK_HZ / 1000) / 1000 / 256;

   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] ctl_r, ctl_nxt;
   logic [7:0] osc_control_reg_r, osc_nxt;
   logic [7:0] osc_tuning_reg_r, tune_nxt;
   logic [1:0] status_r, status_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] watchdog_counter_r, wdt_nxt;
   logic [15:0] post_r, post_nxt;
   logic [7:0] sub_r, sub_nxt;
   wdw_state_t state_r, state_nxt;
   logic rc_tick;
   logic enabled;
   logic window_mode_n;
   logic [3:0] postscale_select;
   logic clr_all;
   logic early_clear;
   logic fs_change;
   logic wr_ctl, wr_cfg, wr_osc, wr_tune, wr_st;
   logic base_done;
   logic tap_hit;

   assign window_mode_n = cfg_r[`WDW_CFG_WIN_BIT];
   assign postscale_select = cfg_r[`WDW_CFG_PS_HI:`WDW_CFG_PS_LO];
   assign enabled = cfg_r[`WDW_CFG_HARD_BIT] || ctl_r[`WDW_CTL_SOFT_BIT];
   assign internal_rc_clock_on = enabled || fscm_enable;
   assign window_flag = watchdog_counter_r >= `WDW_QUADRANT4;

   wdw_tick_gen u_tick (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .run(internal_rc_clock_on),
      .tune(osc_tuning_reg_r),
      .tick(rc_tick)
   );

   // Register writes; the identity word is read-only.
   always_comb begin
      wr_ctl = 1'b0;
      wr_cfg = 1'b0;
      wr_osc = 1'b0;
      wr_tune = 1'b0;
      wr_st = 1'b0;
      if (bus_req.wr) begin
         if (bus_req.addr == `WDW_ADDR_CONTROL) begin
            wr_ctl = 1'b1;
         end else if (bus_req.addr == `WDW_ADDR_CONFIG) begin
            wr_cfg = 1'b1;
         end else if (bus_req.addr == `WDW_ADDR_OSCCTL) begin
            wr_osc = 1'b1;
         end else if (bus_req.addr == `WDW_ADDR_STATUS) begin
            wr_st = 1'b1;
         end else if (bus_req.addr == `WDW_ADDR_TUNE) begin
            wr_tune = 1'b1;
         end
      end
   end

   always_comb begin
      ctl_nxt = ctl_r;
      cfg_nxt = cfg_r;
      osc_nxt = osc_control_reg_r;
      tune_nxt = osc_tuning_reg_r;
      if (wr_ctl) begin
         ctl_nxt = {7'h00, bus_req.wdata[`WDW_CTL_SOFT_BIT]};
      end
      if (wr_cfg) begin
         cfg_nxt = {2'b00, bus_req.wdata[5:0]};
      end
      if (wr_osc) begin
         osc_nxt = bus_req.wdata;
      end
      if (wr_tune) begin
         tune_nxt = bus_req.wdata;
      end
   end

   // Of the oscillator-control writes, only a real change of the frequency field clears the counters.
   assign fs_change = wr_osc &&
      (bus_req.wdata[`WDW_OSC_FS_HI:`WDW_OSC_FS_LO] !=
       osc_control_reg_r[`WDW_OSC_FS_HI:`WDW_OSC_FS_LO]);
   assign early_clear = clear_watchdog_instr && enabled && !window_mode_n &&
      !window_flag;
   assign clr_all = sleep_instr || clear_watchdog_instr || fs_change ||
      clock_fail;

   // Each base-counter step is BASE_TICKS oscillator ticks, so a full
   // 8-bit wrap is the base period.
   assign base_done = rc_tick && (sub_r == 8'(BASE_TICKS - 1));
   assign tap_hit = base_done && (watchdog_counter_r == 8'hFF) &&
      (post_r == ((16'h0001 << postscale_select) - 16'h0001));

   always_comb begin
      sub_nxt = sub_r;
      wdt_nxt = watchdog_counter_r;
      post_nxt = post_r;
      state_nxt = state_r;
      case (state_r)
         WDW_OFF: begin
            sub_nxt = 8'h00;
            wdt_nxt = 8'h00;
            post_nxt = 16'h0000;
            if (enabled && !clr_all) begin
               state_nxt = WDW_RUN;
            end
         end
         WDW_RUN: begin
            if (!enabled) begin
               state_nxt = WDW_OFF;
            end else if (early_clear) begin
               state_nxt = WDW_FIRE;
            end else if (clr_all) begin
               sub_nxt = 8'h00;
               wdt_nxt = 8'h00;
               post_nxt = 16'h0000;
            end else if (tap_hit) begin
               state_nxt = WDW_FIRE;
            end else if (rc_tick) begin
               if (base_done) begin
                  sub_nxt = 8'h00;
                  wdt_nxt = watchdog_counter_r + 8'h01;
                  if (watchdog_counter_r == 8'hFF) begin
                     post_nxt = post_r + 16'h0001;
                  end
               end else begin
                  sub_nxt = sub_r + 8'h01;
               end
            end
         end
         WDW_FIRE: begin
            sub_nxt = 8'h00;
            wdt_nxt = 8'h00;
            post_nxt = 16'h0000;
            state_nxt = WDW_OFF;
         end
         default: state_nxt = WDW_OFF;
      endcase
   end

   // Status bits stick until software writes one; a new event wins.
   always_comb begin
      status_nxt = status_r;
      if (wr_st) begin
         status_nxt = status_r & ~bus_req.wdata[1:0];
      end
      if (state_r == WDW_RUN && tap_hit && enabled && !clr_all) begin
         status_nxt[`WDW_ST_TIMEOUT_BIT] = 1'b1;
      end
      if (state_r == WDW_RUN && early_clear) begin
         status_nxt[`WDW_ST_EARLY_BIT] = 1'b1;
      end
   end

   always_comb begin
      rdata_nxt = 8'h00;
      if (bus_req.rd) begin
         if (bus_req.addr == `WDW_ADDR_CONTROL) begin
            rdata_nxt = {window_flag, 6'h00, ctl_r[`WDW_CTL_SOFT_BIT]};
         end else if (bus_req.addr == `WDW_ADDR_CONFIG) begin
            rdata_nxt = cfg_r;
         end else if (bus_req.addr == `WDW_ADDR_OSCCTL) begin
            rdata_nxt = osc_control_reg_r;
         end else if (bus_req.addr == `WDW_ADDR_STATUS) begin
            rdata_nxt = {6'h00, status_r};
         end else if (bus_req.addr == `WDW_ADDR_IDENT) begin
            rdata_nxt = `WDW_IDENT_VALUE; // Arbitrary value.
         end else if (bus_req.addr == `WDW_ADDR_TUNE) begin
            rdata_nxt = osc_tuning_reg_r;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg_r <= `WDW_CFG_RESET;
         ctl_r <= `WDW_CTL_RESET;
         osc_control_reg_r <= `WDW_OSC_RESET;
         osc_tuning_reg_r <= `WDW_TUNE_RESET;
         status_r <= 2'b00;
         rdata_r <= 8'h00;
         sub_r <= 8'h00;
         watchdog_counter_r <= 8'h00;
         post_r <= 16'h0000;
         state_r <= WDW_OFF;
      end else begin
         cfg_r <= cfg_nxt;
         ctl_r <= ctl_nxt;
         osc_control_reg_r <= osc_nxt;
         osc_tuning_reg_r <= tune_nxt;
         status_r <= status_nxt;
         rdata_r <= rdata_nxt;
         sub_r <= sub_nxt;
         watchdog_counter_r <= wdt_nxt;
         post_r <= post_nxt;
         state_r <= state_nxt;
      end
   end

   assign bus_rdata = rdata_r;
   assign wdt_reset_req = (state_r == WDW_FIRE);
endmodule

// ---- tb/wdw_watchdog_sva.sv ----
/*
 Port checker for wdw_watchdog, bound below the module.
 Assumes one clock, synchronous reset and the reset register values.
*/
`timescale 1ns/1ps
`include "wdw_params.svh"
module wdw_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire wdw_pkg::wdw_bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   // Events and results
   input wire logic sleep_instr,
   input wire logic clear_watchdog_instr,
   input wire logic clock_fail,
   input wire logic fscm_enable,
   input wire logic internal_rc_clock_on,
   input wire logic wdt_reset_req,
   input wire logic window_flag
);
   import wdw_pkg::*;
   // The enables are mirrored from bus writes, as no register is visible.
   logic [7:0] cfg_r, cfg_nxt;
   logic soft_r, soft_nxt;
   logic en;
   assign en = cfg_r[`WDW_CFG_HARD_BIT] | soft_r;
   always_comb begin
      cfg_nxt = cfg_r;
      soft_nxt = soft_r;
      if (bus_req.wr && bus_req.addr == `WDW_ADDR_CONFIG) begin
         cfg_nxt = bus_req.wdata;
      end
      if (bus_req.wr && bus_req.addr == `WDW_ADDR_CONTROL) begin
         soft_nxt = bus_req.wdata[0];
      end
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg_r <= `WDW_CFG_RESET;
         soft_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         soft_r <= soft_nxt;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ctl_read_a: assert property (
      $past(bus_req.rd) && $past(bus_req.addr) == `WDW_ADDR_CONTROL |->
      bus_rdata == {$past(window_flag), 6'h00, $past(soft_r)})
      else $error("control read data wrong");
   cfg_read_a: assert property (
      $past(bus_req.rd) && $past(bus_req.addr) == `WDW_ADDR_CONFIG |->
      bus_rdata == ($past(cfg_r) & 8'h3F))
      else $error("config read data wrong");
   rc_on_a: assert property (
      internal_rc_clock_on == (en || fscm_enable))
      else $error("oscillator enable wrong");
   early_clear_a: assert property (
      clear_watchdog_instr && en && !cfg_r[`WDW_CFG_WIN_BIT] &&
      !window_flag && !wdt_reset_req |=> wdt_reset_req)
      else $error("early clear did not reset");
   reset_pulse_a: assert property (
      wdt_reset_req |=> !wdt_reset_req)
      else $error("reset request longer than one cycle");
   clear_ok_a: assert property (
      clear_watchdog_instr && window_flag |=> !window_flag && !wdt_reset_req)
      else $error("clear in window misbehaved");
   sleep_clear_a: assert property (
      sleep_instr |=> !window_flag)
      else $error("sleep did not clear count");
   fail_clear_a: assert property (
      clock_fail |=> !window_flag)
      else $error("clock failure did not clear count");
   off_quiet_a: assert property (
      !en [*3] |-> !window_flag)
      else $error("count runs while disabled");
endmodule

bind wdw_watchdog wdw_chk chk (.mclk, .sys_rst, .bus_req, .bus_rdata,
   .sleep_instr, .clear_watchdog_instr, .clock_fail, .fscm_enable,
   .internal_rc_clock_on, .wdt_reset_req, .window_flag);

// ---- tb/tb_windowed_watchdog_timer.sv ----
/*
 Self-checking bench for wdw_watchdog.
 Assumes the bound checker; tuning shortens the run.
*/
`timescale 1ns/1ps
`include "wdw_params.svh"
module tb_windowed_watchdog_timer;
   import wdw_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic fscm = 1'b0;
   logic [2:0] ev = 3'h0;
   wdw_bus_req_t req = '0;
   logic [7:0] rdata, d;
   logic rc_on, rst_req, wflag;
   logic [31:0] lfsr = 32'h0000_48f8;
   int failures = 0;
   int compares = 0;
   int c;
   always #20 mclk = ~mclk;
   wdw_watchdog uut (.mclk, .sys_rst, .bus_req(req), .bus_rdata(rdata),
      .sleep_instr(ev[0]), .clear_watchdog_instr(ev[1]),
      .clock_fail(ev[2]), .fscm_enable(fscm),
      .internal_rc_clock_on(rc_on), .wdt_reset_req(rst_req),
      .window_flag(wflag));
   function automatic logic [31:0] rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Tick period scales by (128 + tune) / 128; a band absorbs rounding.
   function automatic logic near(input int n, input int tune, input int t);
      int e;
      e = t * 390 * (128 + tune) / 128;
      return (n * 100 > e * 96) && (n * 100 < e * 104);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req <= '0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      req <= '0;
      // Read data stand only in the cycle after the strobe.
      @(negedge mclk);
      check(rdata, exp);
      @(posedge mclk);
   endtask
   task automatic fire(input logic [2:0] m, input logic exp);
      ev <= m;
      @(posedge mclk);
      ev <= 3'h0;
      // The reset request is a one-cycle pulse, so look mid-cycle.
      @(negedge mclk);
      check(rst_req, exp);
      @(posedge mclk);
   endtask
   task automatic wait_sig(input bit on_req, output int n);
      n = 0;
      @(negedge mclk);
      while ((on_req ? rst_req : wflag) !== 1'b1 && n < 40000) begin
         @(negedge mclk);
         n++;
      end
      @(posedge mclk);
   endtask
   task automatic finish_test;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #(40 * 98000);
      failures++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd(`WDW_ADDR_CONFIG, 8'h3F);
      rd(`WDW_ADDR_CONTROL, 8'h00);
      rd(`WDW_ADDR_IDENT, `WDW_IDENT_VALUE);
      rd(4'h6, 8'h00);
      check(rc_on, 1'b1);
      for (int i = 0; i < 6; i++) begin
         lfsr = rnd(lfsr);
         d = lfsr[7:0];
         wr(`WDW_ADDR_CONFIG, d);
         rd(`WDW_ADDR_CONFIG, d & 8'h3F);
      end
      wr(`WDW_ADDR_CONFIG, 8'h3F);
      $display("registers done");
      wr(`WDW_ADDR_TUNE, 8'hA0);
      fire(3'h2, 1'b0);
      wait_sig(0, c);
      check(near(c, -96, 192), 1'b1);
      rd(`WDW_ADDR_CONTROL, 8'h80);
      wr(`WDW_ADDR_TUNE, 8'h90);
      rd(`WDW_ADDR_TUNE, 8'h90);
      for (int k = 0; k < 4; k++) begin
         if (k < 3) fire(3'h1 << k, 1'b0);
         else wr(`WDW_ADDR_OSCCTL, 8'h50);
         wait_sig(0, c);
         check(near(c, -112, 192), 1'b1);
      end
      rd(`WDW_ADDR_OSCCTL, 8'h50);
      $display("clear events done");
      wr(`WDW_ADDR_CONFIG, 8'h01);
      fire(3'h2, 1'b0);
      lfsr = rnd(lfsr);
      repeat (lfsr[11:0] + 2) @(posedge mclk);
      fire(3'h2, 1'b1);
      rd(`WDW_ADDR_STATUS, 8'h02);
      wait_sig(1, c);
      check(near(c, -112, 256), 1'b1);
      rd(`WDW_ADDR_STATUS, 8'h03);
      wr(`WDW_ADDR_STATUS, 8'h03);
      rd(`WDW_ADDR_STATUS, 8'h00);
      $display("window and timeout done");
      wr(`WDW_ADDR_CONFIG, 8'h3E);
      check(rc_on, 1'b0);
      fscm <= 1'b1;
      @(posedge mclk);
      check(rc_on, 1'b1);
      repeat (10000) @(posedge mclk);
      check(wflag, 1'b0);
      wr(`WDW_ADDR_CONTROL, 8'h01);
      wait_sig(0, c);
      check(near(c, -112, 192), 1'b1);
      rd(`WDW_ADDR_CONTROL, 8'h81);
      $display("enables done");
      finish_test();
   end
endmodule
